/* File: phy_vendor_config_status.sv */
// Function
// - scrambler bypass skips scrambling and descrambling
// - bit 13 bypasses alignment, coding, scrambling
// - bit 12 forces signal detector valid
// - bit 10 selects tx, zero selects fx
// - bit 7 forces good 100 mbps link
// - bit 4 enables automatic reduced power
// - bit 3 resets state machines, self clears
// - bit 2 enables management preamble suppression
// - bit 1 sleeps all but clocks
// - negotiation result loads bits 15:12
// - resolved bits undefined outside negotiation mode
// - reserved bits read zero, writes ignored; the code stores reserved bit 0 as written and reads it back
//
// Our own choices: register access over APB and the register addresses.
`include "phy_vendor_defs.svh"

module phy_vendor_config_status
  import phy_vendor_pkg::*;
(
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SIGNAL_DETECT_RAW,
  input wire logic LINK_100_RAW,
  input wire logic AN_MODE,
  input wire logic AN_DONE,
  input wire logic [3:0] AN_RESULT,
  output logic SCRAMBLE_BYPASS,
  output logic ALIGN_BYPASS,
  output logic SIGNAL_DETECT,
  output logic MEDIA_TX,
  output logic LINK_100_GOOD,
  output logic REDUCED_POWER_EN,
  output logic SM_RESET,
  output logic PREAMBLE_SUPPRESS,
  output logic POWER_DOWN,
  output logic RESOLVED_VALID
);

  // bus decode
  reg_sel_t sel; // register addressed now
  logic wr_cfg; // write access phase to configuration
  logic wr_stat; // write access phase to status
  logic asleep; // sleep bit currently set
  logic wake; // write that clears sleep
  logic smr_start; // request for state machine reset

  // storage
  logic [15:0] cfg_reg; // configuration, bit 3 kept zero
  logic [3:0] res_reg; // resolved mode bits
  logic an_seen_reg; // negotiation result captured
  smr_state_t smr_reg; // reset sequencer state
  logic [3:0] smr_cnt_reg; // cycles left in reset
  logic [31:0] prdata_reg; // read data, loaded in setup
  logic [31:0] prdata_next;

  // pin synchronisers, first stage read only by second
  logic sd_meta_reg;
  logic sd_sync_reg;
  logic link_meta_reg;
  logic link_sync_reg;
  logic sd_out_reg; // registered signal detect
  logic link_out_reg; // registered link status

  // apb decode, zero wait state slave
  always_comb begin
    sel = decode_sel(PADDR);
    wr_cfg = PSEL && PENABLE && PWRITE && (sel == SEL_CONFIG);
    wr_stat = PSEL && PENABLE && PWRITE && (sel == SEL_STATUS);
  end

  assign asleep = cfg_reg[`CFG_SLEEP];
  assign wake = wr_cfg && asleep && !PWDATA[`CFG_SLEEP];
  // a set write while awake starts a reset; so does waking
  assign smr_start = (wr_cfg && !asleep && PWDATA[`CFG_SM_RST]) || wake;

  // handshake is combinational; never stalls
  assign PREADY = 1'b1;
  // unmapped addresses answer with an error in the access phase
  assign PSLVERR = PSEL && PENABLE && (sel == SEL_NONE);

  // configuration register
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_reg <= `CFG_RESET;
    end else if (wr_cfg && !asleep) begin
      // reserved bits dropped by the mask
      // bit 0 stored as written, software keeps it zero
      cfg_reg <= PWDATA[15:0] & `CFG_WMASK & ~(16'h0001 << `CFG_SM_RST);
    end else if (wr_cfg) begin
      // while asleep only the sleep bit moves, so the
      // configuration from before sleep comes back
      cfg_reg[`CFG_SLEEP] <= PWDATA[`CFG_SLEEP];
    end
  end

  // state machine reset sequencer, self clearing
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      smr_reg <= SMR_IDLE;
      smr_cnt_reg <= 4'h0;
    end else if (smr_start) begin
      // a new request restarts the full duration
      smr_reg <= SMR_BUSY;
      smr_cnt_reg <= 4'(`SMR_CYCLES - 1);
    end else begin
      unique case (smr_reg)
        SMR_IDLE: begin
          smr_cnt_reg <= 4'h0;
        end
        SMR_BUSY: begin
          // clear bit once the hold time has elapsed
          if (smr_cnt_reg == 4'h0) begin
            smr_reg <= SMR_IDLE;
          end else begin
            smr_cnt_reg <= smr_cnt_reg - 4'h1;
          end
        end
      endcase
    end
  end

  // resolved mode bits, loaded only by negotiation
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      res_reg <= `STAT_RES_RESET;
      an_seen_reg <= 1'b0;
    end else if (AN_DONE) begin
      // bus writes never reach this register
      res_reg <= AN_RESULT;
      an_seen_reg <= 1'b1;
    end else if (!AN_MODE) begin
      // forced modes make the result meaningless
      an_seen_reg <= 1'b0;
    end
  end

  // result trustworthy only in negotiation mode
  assign RESOLVED_VALID = an_seen_reg && AN_MODE;

  // read data mux, captured in the setup phase
  always_comb begin
    prdata_next = 32'h0000_0000;
    unique case (sel)
      SEL_CONFIG: begin
        prdata_next[15:0] = cfg_reg;
        prdata_next[`CFG_SM_RST] = (smr_reg == SMR_BUSY);
      end
      SEL_STATUS: begin
        // bits 11:0 are reserved and read zero
        prdata_next[15:`STAT_RES_LSB] = res_reg;
      end
      SEL_NONE: begin
        prdata_next = 32'h0000_0000;
      end
    endcase
  end

  // read data register; loading in setup keeps the read
  // path one flop deep at the cost of a cycle of latency
  // that the zero wait access phase hides
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prdata_reg <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      prdata_reg <= prdata_next;
    end
  end

  assign PRDATA = prdata_reg;

  // two flop synchronisers for analog front end levels
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sd_meta_reg <= 1'b0;
      sd_sync_reg <= 1'b0;
      link_meta_reg <= 1'b0;
      link_sync_reg <= 1'b0;
    end else begin
      sd_meta_reg <= SIGNAL_DETECT_RAW;
      sd_sync_reg <= sd_meta_reg;
      link_meta_reg <= LINK_100_RAW;
      link_sync_reg <= link_meta_reg;
    end
  end

  // status outputs with overrides
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sd_out_reg <= 1'b0;
      link_out_reg <= 1'b0;
    end else begin
      // debug override forces a valid signal
      sd_out_reg <= sd_sync_reg || cfg_reg[`CFG_SD_OVR];
      // forced link ignores the line
      link_out_reg <= link_sync_reg || cfg_reg[`CFG_FORCE_LINK];
    end
  end

  // configuration drives the datapath directly from flops
  assign SCRAMBLE_BYPASS = cfg_reg[`CFG_SCR_BYP];
  assign ALIGN_BYPASS = cfg_reg[`CFG_ALIGN_BYP];
  assign MEDIA_TX = cfg_reg[`CFG_MEDIA_TX];
  assign REDUCED_POWER_EN = cfg_reg[`CFG_RPD_EN];
  assign PREAMBLE_SUPPRESS = cfg_reg[`CFG_PRE_SUP];
  assign POWER_DOWN = cfg_reg[`CFG_SLEEP];
  assign SIGNAL_DETECT = sd_out_reg;
  assign LINK_100_GOOD = link_out_reg;
  assign SM_RESET = (smr_reg == SMR_BUSY);

  // checks sample on the core clock and stay quiet in reset
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!ARST_N);

  // awake write to configuration
  sequence cfg_wr_awake_s;
    wr_cfg && !asleep;
  endsequence

  // full reset hold, ten cycles at 100 ns
  sequence smr_hold_s;
    SM_RESET[*8] ##1 SM_RESET[*2];
  endsequence

  scr_bypass_a: assert property (
    cfg_wr_awake_s |=> SCRAMBLE_BYPASS == $past(PWDATA[14]))
    else $error("scrambler bypass not taken from write");

  align_bypass_a: assert property (
    cfg_wr_awake_s |=> ALIGN_BYPASS == $past(PWDATA[13]))
    else $error("alignment bypass not taken from write");

  sd_force_a: assert property (
    cfg_reg[12] ##1 cfg_reg[12] |-> SIGNAL_DETECT)
    else $error("signal detect override not applied");

  media_sel_a: assert property (
    cfg_wr_awake_s |=> MEDIA_TX == $past(PWDATA[10]))
    else $error("media select not taken from write");

  link_force_a: assert property (
    cfg_reg[7] ##1 cfg_reg[7] |-> LINK_100_GOOD)
    else $error("forced link not reported");

  rpd_enable_a: assert property (
    cfg_wr_awake_s |=> REDUCED_POWER_EN == $past(PWDATA[4]))
    else $error("reduced power enable not taken");

  smr_hold_a: assert property (
    smr_start |=> smr_hold_s)
    else $error("state machine reset too short");

  smr_clear_a: assert property (
    $fell(SM_RESET) |-> $past(smr_cnt_reg) == 4'h0 && !$past(smr_start))
    else $error("state machine reset cleared early");

  preamble_sup_a: assert property (
    cfg_wr_awake_s |=> PREAMBLE_SUPPRESS == $past(PWDATA[2]))
    else $error("preamble suppression not taken");

  sleep_enter_a: assert property (
    wr_cfg && !asleep && PWDATA[`CFG_SLEEP] |=> POWER_DOWN)
    else $error("sleep write did not power down");

  wake_restore_a: assert property (
    wake |=> !POWER_DOWN && SM_RESET
      && cfg_reg[15:2] == $past(cfg_reg[15:2]))
    else $error("wake did not restore or reset");

  resolved_load_a: assert property (
    AN_DONE |=> res_reg == $past(AN_RESULT))
    else $error("resolved mode not loaded");

  rsvd_zero_a: assert property (
    PSEL && PENABLE && !PWRITE && sel == SEL_STATUS
      |-> PRDATA[11:0] == 12'h000)
    else $error("reserved status bits not zero");

  ro_keep_a: assert property (
    wr_stat && !AN_DONE |=> $stable(res_reg))
    else $error("write changed resolved mode bits");

  // read of the configuration: setup, then access
  sequence cfg_read_s;
    (PSEL && !PENABLE && !PWRITE && sel == SEL_CONFIG) ##1 (PSEL && PENABLE);
  endsequence

  cfg_read_a: assert property (
    cfg_read_s |-> PRDATA[`CFG_SM_RST] == $past(SM_RESET))
    else $error("reset field not shown on read");

  cfg_rsvd_a: assert property (
    cfg_read_s |-> (PRDATA[15:0] & ~`CFG_WMASK) == 16'h0000)
    else $error("reserved configuration bits not zero");

  upper_zero_a: assert property (
    PSEL && PENABLE && !PWRITE |-> PRDATA[31:16] == 16'h0000)
    else $error("upper read data bits not zero");

  unmapped_rd_a: assert property (
    PSEL && PENABLE && !PWRITE && sel == SEL_NONE
      |-> PSLVERR && PRDATA == 32'h0000_0000)
    else $error("unmapped read not refused");

  unmapped_wr_a: assert property (
    PSEL && PENABLE && PWRITE && sel == SEL_NONE |=> $stable(cfg_reg))
    else $error("unmapped write changed configuration");

  sleep_keep_a: assert property (
    wr_cfg && asleep |=> cfg_reg[15:2] == $past(cfg_reg[15:2])
      && cfg_reg[0] == $past(cfg_reg[0]))
    else $error("configuration moved during sleep");

  sleep_no_smr_a: assert property (
    wr_cfg && asleep && PWDATA[`CFG_SLEEP] |=> !$rose(SM_RESET))
    else $error("state machine reset started while asleep");

  sd_line_a: assert property (
    !cfg_reg[`CFG_SD_OVR] ##1 !cfg_reg[`CFG_SD_OVR]
      |-> SIGNAL_DETECT == $past(sd_sync_reg))
    else $error("signal detect does not follow the line");

  link_line_a: assert property (
    !cfg_reg[`CFG_FORCE_LINK] ##1 !cfg_reg[`CFG_FORCE_LINK]
      |-> LINK_100_GOOD == $past(link_sync_reg))
    else $error("link status does not follow the line");

  res_hold_a: assert property (
    !AN_DONE |=> $stable(res_reg))
    else $error("resolved mode moved without negotiation");

  an_forced_a: assert property (
    !AN_MODE |-> !RESOLVED_VALID)
    else $error("resolved mode flagged valid in forced mode");

endmodule

/* File: phy_vendor_defs.svh */
`ifndef PHY_VENDOR_DEFS_SVH
`define PHY_VENDOR_DEFS_SVH

// register indices; byte address is four times the index
`define CFG_INDEX 10'h010
`define STAT_INDEX 10'h011

// configuration register field positions
`define CFG_SCR_BYP 14
`define CFG_ALIGN_BYP 13
`define CFG_SD_OVR 12
`define CFG_MEDIA_TX 10
`define CFG_FORCE_LINK 7
`define CFG_RPD_EN 4
`define CFG_SM_RST 3
`define CFG_PRE_SUP 2
`define CFG_SLEEP 1
`define CFG_RSVD0 0

// configuration reset value and writable bits
`define CFG_RESET 16'h0414
`define CFG_WMASK 16'h749f

// status register: resolved mode field, msb first
`define STAT_RES_LSB 12
`define STAT_RES_RESET 4'hf

// state machine reset duration
`define CLK_PERIOD_NS 100
`define SMR_TIME_NS 1000
`define SMR_CYCLES ((`SMR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: phy_vendor_pkg.sv */
`include "phy_vendor_defs.svh"

package phy_vendor_pkg;

  // register selected by an apb address
  typedef enum logic [1:0] {SEL_NONE, SEL_CONFIG, SEL_STATUS} reg_sel_t;

  // state machine reset sequencer
  typedef enum logic {SMR_IDLE, SMR_BUSY} smr_state_t;

  // word aligned decode; low address bits must be zero
  function automatic reg_sel_t decode_sel(input logic [11:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr[1:0] == 2'b00 && addr[11:2] == `CFG_INDEX) begin
      sel = SEL_CONFIG;
    end else if (addr[1:0] == 2'b00 && addr[11:2] == `STAT_INDEX) begin
      sel = SEL_STATUS;
    end
    return sel;
  endfunction

endpackage

/* File: phy_vendor_config_status_tb.sv */
`include "phy_vendor_defs.svh"

module phy_vendor_config_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] CFG_A = {`CFG_INDEX, 2'b00};
  localparam logic [11:0] STA_A = {`STAT_INDEX, 2'b00};
  logic mclk, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sd_raw = 1'b0, link_raw = 1'b0;
  logic an_mode = 1'b0, an_done = 1'b0;
  logic [3:0] an_res = 4'h0;
  logic scr_byp, aln_byp, sig_det, media_tx, link_good, rpd_en, sm_rst;
  logic pre_sup, pwr_dn, res_valid;
  logic [32:0] expq[$]; // {error, read data} per transfer, oldest first
  logic [32:0] exp_v;
  logic [31:0] seed = 32'h5a42;
  logic [15:0] c, r;
  int fail_count = 0, tests_run = 0, run = 0, runs = 0;

  phy_vendor_config_status DUT (.MCLK(mclk), .ARST_N(arst_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SIGNAL_DETECT_RAW(sd_raw), .LINK_100_RAW(link_raw), .AN_MODE(an_mode),
    .AN_DONE(an_done), .AN_RESULT(an_res), .SCRAMBLE_BYPASS(scr_byp),
    .ALIGN_BYPASS(aln_byp), .SIGNAL_DETECT(sig_det), .MEDIA_TX(media_tx),
    .LINK_100_GOOD(link_good), .REDUCED_POWER_EN(rpd_en),
    .SM_RESET(sm_rst), .PREAMBLE_SUPPRESS(pre_sup), .POWER_DOWN(pwr_dn),
    .RESOLVED_VALID(res_valid));

  // 100 ns clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // xorshift source, fixed start
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  task automatic check(input string nm, input logic [32:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one apb transfer; the expectation is queued before the setup cycle
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [15:0] d, input logic [32:0] e);
    int n;
    n = 0;
    expq.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // bounded wait for the slave's answer
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        fail_count++;
        end_of_test();
      end
      @(posedge mclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // control outputs against a config value; raw inputs held low
  task automatic outs(input logic [15:0] v);
    check("ctl", {scr_byp, aln_byp, media_tx, rpd_en, pre_sup, pwr_dn,
      link_good, sig_det}, {v[14], v[13], v[10], v[4], v[2], v[1], v[7],
      v[12]});
  endtask

  // watcher: completed transfers and lengths of state machine resets
  always @(posedge mclk) begin
    if (psel && penable && pready) begin
      if (expq.size() == 0) begin
        check("queue", 33'h0, 33'h1);
      end else begin
        exp_v = expq.pop_front();
        if (pwrite) begin
          check("pslverr", pslverr, exp_v[32]);
        end else begin
          check("read", {pslverr, prdata}, exp_v);
        end
      end
    end
    if (sm_rst === 1'b1) begin
      run++;
    end else if (run != 0) begin
      check("sm_len", run, `SMR_CYCLES);
      runs++;
      run = 0;
    end
  end

  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    outs(`CFG_RESET);
    apb(1'b0, CFG_A, 16'h0, {17'h0, `CFG_RESET});
    apb(1'b0, STA_A, 16'h0, {17'h0, `STAT_RES_RESET, 12'h0});
    // random data; reserved bits set in the write must not stick
    repeat (4) begin
      r = xs();
      c = r & 16'h7494;
      apb(1'b1, CFG_A, r & 16'hfff4, 33'h0);
      apb(1'b0, CFG_A, 16'h0, {17'h0, c});
      outs(c);
    end
    // reset request shows in the field until it clears itself
    apb(1'b1, CFG_A, c | 16'h0008, 33'h0);
    apb(1'b0, CFG_A, 16'h0, {17'h0, c | 16'h0008});
    repeat (12) @(posedge mclk);
    apb(1'b0, CFG_A, 16'h0, {17'h0, c});
    // sleep keeps the configuration, wake restarts the machines
    apb(1'b1, CFG_A, c | 16'h0002, 33'h0);
    outs(c | 16'h0002);
    apb(1'b1, CFG_A, ~c & 16'hfffe, 33'h0);
    apb(1'b0, CFG_A, 16'h0, {17'h0, c | 16'h0002});
    apb(1'b1, CFG_A, c, 33'h0);
    apb(1'b0, CFG_A, 16'h0, {17'h0, c | 16'h0008});
    outs(c);
    repeat (12) @(posedge mclk);
    // unmapped and misaligned places answer with an error
    apb(1'b1, 12'h048, 16'hffff, {1'b1, 32'h0});
    apb(1'b0, 12'h048, 16'h0, {1'b1, 32'h0});
    apb(1'b0, CFG_A + 12'h2, 16'h0, {1'b1, 32'h0});
    apb(1'b0, CFG_A, 16'h0, {17'h0, c});
    // each one-hot resolved mode, status writes ignored
    an_mode <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      an_res <= 4'h1 << i;
      an_done <= 1'b1;
      @(posedge mclk);
      an_done <= 1'b0;
      @(posedge mclk);
      apb(1'b1, STA_A, 16'hffff, 33'h0);
      apb(1'b0, STA_A, 16'h0, {17'h0, 4'h1 << i, 12'h0});
      check("res_valid", res_valid, 33'h1);
    end
    an_mode <= 1'b0;
    repeat (2) @(posedge mclk);
    check("res_valid", res_valid, 33'h0);
    // reset in mid-run brings every default back
    arst_n <= 1'b0;
    @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    outs(`CFG_RESET);
    apb(1'b0, STA_A, 16'h0, {17'h0, `STAT_RES_RESET, 12'h0});
    apb(1'b0, CFG_A, 16'h0, {17'h0, `CFG_RESET});
    check("res_valid", res_valid, 33'h0);
    // front-end levels pass the synchronisers, no override set
    sd_raw <= 1'b1;
    link_raw <= 1'b1;
    repeat (2) @(posedge mclk);
    check("raw_early", {sig_det, link_good}, 33'h0);
    repeat (2) @(posedge mclk);
    check("raw_in", {sig_det, link_good}, 33'h3);
    check("sm_runs", runs, 33'h2);
    check("queue", expq.size(), 33'h0);
    end_of_test();
  end
endmodule
